/* rtl/sbr_status.sv */
// status byte reporting: three status bytes, masks and service request
`timescale 1ns/1ns
`include "sbr_defs.svh"

module sbr_status
    import sbr_pkg::*;
#(
    parameter logic [31:0] WARMUP_CYC = 32'(`SBR_WARMUP_CYC)
) (
    input  wire logic         clk_sys_i,
    input  wire logic         reset_i,

    input  wire sbr_query_s   query_i,
    input  wire sbr_mask_wr_s mask_wr_i,
    input  wire logic         psc_wr_i,
    input  wire logic         psc_val_i,
    input  wire logic         clear_status_i,
    input  wire logic         serial_poll_done_i,

    input  wire sbr_std_ev_s  std_ev_i,
    input  wire sbr_gen_ev_s  gen_ev_i,

    input  wire logic         sweep_idle_i,
    input  wire logic         mod_enabled_i,
    input  wire logic         panel_service_request_i,
    input  wire logic         out_queue_nonempty_i,
    input  wire logic         cmd_queue_empty_i,
    input  wire logic         ext_clk_locked_i,

    input  wire logic         nv_psc_i,
    input  wire logic [7:0]   nv_sp_mask_i,
    input  wire logic [7:0]   nv_std_mask_i,
    input  wire logic [7:0]   nv_gen_mask_i,

    output logic              reply_valid_o,
    output logic [7:0]        reply_data_o,
    output logic              srq_o,
    output logic [7:0]        sp_mask_o,
    output logic [7:0]        std_mask_o,
    output logic [7:0]        gen_mask_o,
    output logic              psc_o,
    output logic              init_done_o
);

    // ============================================================
    // clear decode, shared by both clearable bytes
    function automatic logic [7:0] sbr_clr_mask(
        input logic       by_bit,
        input logic [2:0] idx
    );
        sbr_clr_mask = by_bit ? (8'h01 << idx) : `SBR_ALL_BITS;
    endfunction

    // ============================================================
    // declarations
    sbr_state_e  state_r;
    logic [7:0]  sp_mask_r;
    logic [7:0]  std_mask_r;
    logic [7:0]  gen_mask_r;
    logic        psc_r;
    logic [7:0]  std_r;
    logic [7:0]  gen_r;
    logic        warm_r;
    logic [31:0] warm_cnt_r;
    logic        ext_meta_r;
    logic        ext_sync_r;
    logic        rqs_r;
    logic [7:0]  sp_prev_r;
    logic        reply_valid_r;
    logic [7:0]  reply_data_r;

    logic [7:0]  sp_val;
    logic [7:0]  sp_unm;
    logic        sp_rise;
    logic [7:0]  std_set;
    logic [7:0]  gen_set;
    logic [7:0]  std_clr;
    logic [7:0]  gen_clr;
    logic [7:0]  read_byte;
    logic        rd_std;
    logic        rd_gen;
    logic        pon;

    // ============================================================
    // power-up sequencing
    // the stored setting is caught one edge after release, never by the reset itself
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            state_r <= SBR_ST_INIT;
        end else begin
            case (state_r)
                SBR_ST_INIT: state_r <= SBR_ST_RUN;
                SBR_ST_RUN:  state_r <= SBR_ST_RUN;
                default:     state_r <= SBR_ST_INIT;
            endcase
        end
    end

    assign pon = (state_r == SBR_ST_INIT);

    // ============================================================
    // power-on-clear setting
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            psc_r <= 1'b0;
        end else if (pon) begin
            psc_r <= nv_psc_i;
        end else if (psc_wr_i) begin
            psc_r <= psc_val_i;
        end
    end

    // ============================================================
    // enable masks
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            sp_mask_r  <= `SBR_BYTE_RST;
            std_mask_r <= `SBR_BYTE_RST;
            gen_mask_r <= `SBR_BYTE_RST;
        end else if (pon) begin
            // cleared masks when the setting asks, otherwise restored ones
            sp_mask_r  <= nv_psc_i ? `SBR_BYTE_RST : nv_sp_mask_i;
            std_mask_r <= nv_psc_i ? `SBR_BYTE_RST : nv_std_mask_i;
            gen_mask_r <= nv_psc_i ? `SBR_BYTE_RST : nv_gen_mask_i;
        end else if (mask_wr_i.stb) begin
            case (mask_wr_i.which)
                SBR_MASK_SP:  sp_mask_r  <= mask_wr_i.value;
                SBR_MASK_STD: std_mask_r <= mask_wr_i.value;
                SBR_MASK_GEN: gen_mask_r <= mask_wr_i.value;
                default:      sp_mask_r  <= sp_mask_r;
            endcase
        end
    end

    // ============================================================
    // external clock lock comes from a pin: two-stage synchroniser
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            ext_meta_r <= 1'b0;
            ext_sync_r <= 1'b0;
        end else begin
            ext_meta_r <= ext_clk_locked_i;
            ext_sync_r <= ext_meta_r;
        end
    end

    // ============================================================
    // warm-up timer
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            warm_cnt_r <= 32'h0000_0000;
            warm_r     <= 1'b0;
        end else if (!warm_r) begin
            warm_cnt_r <= warm_cnt_r + 32'h0000_0001;
            if (warm_cnt_r >= WARMUP_CYC - 32'h0000_0001) begin
                warm_r <= 1'b1;
            end
        end
    end

    // ============================================================
    // read-side clears
    assign rd_std  = query_i.stb && (query_i.sel == SBR_SEL_STD);
    assign rd_gen  = query_i.stb && (query_i.sel == SBR_SEL_GEN);

    assign std_clr = clear_status_i ? `SBR_ALL_BITS
                   : (rd_std ? sbr_clr_mask(query_i.by_bit, query_i.idx) : `SBR_BYTE_RST);
    assign gen_clr = clear_status_i ? `SBR_ALL_BITS
                   : (rd_gen ? sbr_clr_mask(query_i.by_bit, query_i.idx) : `SBR_BYTE_RST);

    // ============================================================
    // event set vectors, sampled as single-cycle pulses
    always_comb begin
        std_set                     = `SBR_BYTE_RST;
        std_set[`SBR_STD_QUERY_ERR] = std_ev_i.reply_overflow;
        std_set[`SBR_STD_EXEC_ERR]  = std_ev_i.exec_err;
        std_set[`SBR_STD_CMD_ERR]   = std_ev_i.cmd_err;
        std_set[`SBR_STD_KEY]       = std_ev_i.key_press;
        std_set[`SBR_STD_PON]       = pon;
    end

    always_comb begin
        gen_set                    = `SBR_BYTE_RST;
        gen_set[`SBR_GEN_TRIG]     = gen_ev_i.triggered;
        gen_set[`SBR_GEN_TRIG_ERR] = gen_ev_i.trig_rate_err;
        gen_set[`SBR_GEN_CLK_ERR]  = gen_ev_i.clk_fault;
        gen_set[`SBR_GEN_TEST_ERR] = gen_ev_i.test_fail;
        gen_set[`SBR_GEN_CAL_ERR]  = gen_ev_i.cal_fail;
        gen_set[`SBR_GEN_MEM_ERR]  = gen_ev_i.mem_corrupt;
    end

    // ============================================================
    // standard event byte
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            std_r <= `SBR_BYTE_RST;
        end else begin
            // set beats a clear landing in the same cycle
            std_r <= (std_r & ~std_clr) | std_set;
        end
    end

    // ============================================================
    // generator event byte, per-bit behaviour
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_gen
            if (gi == `SBR_GEN_EXT_CLK) begin : g_lvl
                assign gen_r[gi] = ext_sync_r;
            end else if (gi == `SBR_GEN_WARM) begin : g_warm
                // sticky by nature: reads and clear-status leave it alone
                assign gen_r[gi] = warm_r;
            end else begin : g_latch
                logic bit_r;
                always_ff @(posedge clk_sys_i or posedge reset_i) begin
                    if (reset_i) begin
                        bit_r <= 1'b0;
                    end else begin
                        bit_r <= (bit_r & ~gen_clr[gi]) | gen_set[gi];
                    end
                end
                assign gen_r[gi] = bit_r;
            end
        end
    endgenerate

    // ============================================================
    // serial poll byte, a pure summary
    always_comb begin
        sp_val                    = `SBR_BYTE_RST;
        sp_val[`SBR_SP_SWEEP_IDLE] = sweep_idle_i;
        sp_val[`SBR_SP_MOD_ON]     = mod_enabled_i;
        sp_val[`SBR_SP_PANEL_SRQ]  = panel_service_request_i;
        sp_val[`SBR_SP_GEN_SUM]    = |(gen_r & gen_mask_r);
        sp_val[`SBR_SP_REPLY_RDY]  = out_queue_nonempty_i;
        sp_val[`SBR_SP_STD_SUM]    = |(std_r & std_mask_r);
        sp_val[`SBR_SP_RQS]        = rqs_r;
        sp_val[`SBR_SP_CMD_EMPTY]  = cmd_queue_empty_i;
    end

    // the request bit cannot request itself
    always_comb begin
        sp_unm              = sp_val & sp_mask_r;
        sp_unm[`SBR_SP_RQS] = 1'b0;
    end

    assign sp_rise = |(sp_unm & ~sp_prev_r);

    // ============================================================
    // service request edge detection
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            sp_prev_r <= `SBR_BYTE_RST;
        end else begin
            sp_prev_r <= sp_unm;
        end
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            rqs_r <= 1'b0;
        end else if (sp_rise) begin
            rqs_r <= 1'b1;
        end else if (serial_poll_done_i || clear_status_i) begin
            rqs_r <= 1'b0;
        end
    end

    // ============================================================
    // query answers, taken from the value before any clear
    always_comb begin
        case (query_i.sel)
            SBR_SEL_SPOLL:    read_byte = sp_val;
            SBR_SEL_STD:      read_byte = std_r;
            SBR_SEL_GEN:      read_byte = gen_r;
            SBR_SEL_SP_MASK:  read_byte = sp_mask_r;
            SBR_SEL_STD_MASK: read_byte = std_mask_r;
            SBR_SEL_GEN_MASK: read_byte = gen_mask_r;
            SBR_SEL_PSC:      read_byte = {7'h00, psc_r};
            default:          read_byte = `SBR_BYTE_RST;
        endcase
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            reply_valid_r <= 1'b0;
            reply_data_r  <= `SBR_BYTE_RST;
        end else begin
            reply_valid_r <= query_i.stb;
            if (query_i.stb) begin
                reply_data_r <= query_i.by_bit ? {7'h00, read_byte[query_i.idx]} : read_byte;
            end
        end
    end

    // ============================================================
    // outputs
    assign reply_valid_o = reply_valid_r;
    assign reply_data_o  = reply_data_r;
    assign srq_o         = rqs_r;
    assign sp_mask_o     = sp_mask_r;
    assign std_mask_o    = std_mask_r;
    assign gen_mask_o    = gen_mask_r;
    assign psc_o         = psc_r;
    assign init_done_o   = (state_r == SBR_ST_RUN);

endmodule

/* rtl/sbr_defs.svh */
// status byte reporting: bit positions, reset values and timing constants
// Contract
// - three separate eight-bit status bytes kept
// - power-on clears masks or restores stored ones
// - poll bits 0-2 show sweep, modulation, panel
// - only mask-enabled bits feed the summaries
// - poll bits 3,5 summarize generator, standard
// - poll bit 4 shows reply queue nonempty
// - poll bit 7 shows command queue empty
// - unmasked poll bit setting raises request
// - one request per rising bit only
// - standard bit 2 latches reply overflow
// - standard bit 4 latches execution error
// - standard bit 5 latches command error
// - standard bits 6,7 latch key, power-on
// - standard bits stick until read or clear
// - generator bits 0,1 latch trigger events
// - generator bit 2 follows external clock lock
// - generator bit 4 sets after warm-up, stays
// - generator bits 3,5,6,7 latch faults
// - latched generator bits stick until read/clear
// - whole read clears byte, bit read clears bit
// - reading poll byte never changes it
`ifndef SBR_DEFS_SVH
`define SBR_DEFS_SVH

// ============================================================
// serial poll byte bits
`define SBR_SP_SWEEP_IDLE 0
`define SBR_SP_MOD_ON     1
`define SBR_SP_PANEL_SRQ  2
`define SBR_SP_GEN_SUM    3
`define SBR_SP_REPLY_RDY  4
`define SBR_SP_STD_SUM    5
`define SBR_SP_RQS        6
`define SBR_SP_CMD_EMPTY  7

// ============================================================
// standard event byte bits
`define SBR_STD_QUERY_ERR 2
`define SBR_STD_EXEC_ERR  4
`define SBR_STD_CMD_ERR   5
`define SBR_STD_KEY       6
`define SBR_STD_PON       7

// ============================================================
// generator event byte bits
`define SBR_GEN_TRIG      0
`define SBR_GEN_TRIG_ERR  1
`define SBR_GEN_EXT_CLK   2
`define SBR_GEN_CLK_ERR   3
`define SBR_GEN_WARM      4
`define SBR_GEN_TEST_ERR  5
`define SBR_GEN_CAL_ERR   6
`define SBR_GEN_MEM_ERR   7

// ============================================================
// reset values and timing
`define SBR_BYTE_RST      8'h00
`define SBR_ALL_BITS      8'hFF
`define SBR_CLK_HZ        25000000
`define SBR_WARMUP_S      120
`define SBR_WARMUP_CYC    (64'(`SBR_WARMUP_S) * 64'(`SBR_CLK_HZ))

`endif

/* rtl/sbr_pkg.sv */
// status byte reporting: shared types
package sbr_pkg;

    // ============================================================
    // query and mask-write targets, power-up states
    typedef enum logic [2:0] {
        SBR_SEL_SPOLL    = 3'h0,
        SBR_SEL_STD      = 3'h1,
        SBR_SEL_GEN      = 3'h2,
        SBR_SEL_SP_MASK  = 3'h3,
        SBR_SEL_STD_MASK = 3'h4,
        SBR_SEL_GEN_MASK = 3'h5,
        SBR_SEL_PSC      = 3'h6
    } sbr_sel_e;

    typedef enum logic [1:0] {
        SBR_MASK_SP  = 2'h0,
        SBR_MASK_STD = 2'h1,
        SBR_MASK_GEN = 2'h2
    } sbr_mask_e;

    typedef enum logic [1:0] {
        SBR_ST_INIT = 2'b01,
        SBR_ST_RUN  = 2'b10
    } sbr_state_e;

    // ============================================================
    // request and event carriers
    typedef struct packed {
        logic       stb;
        sbr_sel_e   sel;
        logic       by_bit;
        logic [2:0] idx;
    } sbr_query_s;

    typedef struct packed {
        logic       stb;
        sbr_mask_e  which;
        logic [7:0] value;
    } sbr_mask_wr_s;

    typedef struct packed {
        logic reply_overflow;
        logic exec_err;
        logic cmd_err;
        logic key_press;
    } sbr_std_ev_s;

    typedef struct packed {
        logic triggered;
        logic trig_rate_err;
        logic clk_fault;
        logic test_fail;
        logic cal_fail;
        logic mem_corrupt;
    } sbr_gen_ev_s;

endpackage

/* tb/sbr_status_props.sv */
// assertion checker for the status byte block
`timescale 1ns/1ns
module sbr_status_props
    import sbr_pkg::*;
(
    input wire logic         clk_sys_i,
    input wire logic         reset_i,
    input wire sbr_query_s   query_i,
    input wire sbr_mask_wr_s mask_wr_i,
    input wire logic         clear_status_i,
    input wire sbr_std_ev_s  std_ev_i,
    input wire logic         sweep_idle_i,
    input wire logic         mod_enabled_i,
    input wire logic         out_queue_nonempty_i,
    input wire logic         cmd_queue_empty_i,
    input wire logic         ext_clk_locked_i,
    input wire logic         reply_valid_o,
    input wire logic [7:0]   reply_data_o,
    input wire logic         srq_o,
    input wire logic [7:0]   sp_mask_o,
    input wire logic [7:0]   gen_mask_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);

    // ============================================================
    // whole-byte query of one target
    sequence s_rd(sbr_sel_e s);
        query_i.stb && query_i.sel == s && !query_i.by_bit;
    endsequence

    // ============================================================
    // properties
    a_reply_one_later: assert property (query_i.stb |=> reply_valid_o)
        else $error("reply missing one cycle after query");
    a_reply_has_cause: assert property (reply_valid_o |-> $past(query_i.stb))
        else $error("reply without a query");
    a_poll_levels: assert property (s_rd(SBR_SEL_SPOLL) |=> reply_data_o[7] == $past(cmd_queue_empty_i)
        && reply_data_o[4] == $past(out_queue_nonempty_i) && reply_data_o[1:0] == $past({mod_enabled_i, sweep_idle_i}))
        else $error("poll byte levels wrong");
    a_poll_rqs_bit: assert property (s_rd(SBR_SEL_SPOLL) |=> reply_data_o[6] == $past(srq_o))
        else $error("poll bit 6 differs from request");
    a_srq_on_rise: assert property (sp_mask_o[7] && $rose(cmd_queue_empty_i) |=> srq_o)
        else $error("no request on unmasked rise");
    a_std_sticky: assert property (std_ev_i.exec_err ##1 s_rd(SBR_SEL_STD) |=> reply_data_o[4])
        else $error("execution error bit not latched");
    a_clear_status: assert property ((clear_status_i && std_ev_i == '0) ##1 s_rd(SBR_SEL_STD)
        |=> reply_data_o == 8'h00)
        else $error("standard byte not cleared");
    a_ext_follow: assert property (ext_clk_locked_i [*4] ##0 s_rd(SBR_SEL_GEN) |=> reply_data_o[2])
        else $error("external clock bit not following");
    a_gen_mask_wr: assert property (mask_wr_i.stb && mask_wr_i.which == SBR_MASK_GEN
        |=> gen_mask_o == $past(mask_wr_i.value))
        else $error("generator mask not written");
endmodule

bind sbr_status sbr_status_props u_props (.clk_sys_i, .reset_i, .query_i, .mask_wr_i, .clear_status_i, .std_ev_i,
    .sweep_idle_i, .mod_enabled_i, .out_queue_nonempty_i, .cmd_queue_empty_i, .ext_clk_locked_i,
    .reply_valid_o, .reply_data_o, .srq_o, .sp_mask_o, .gen_mask_o);

/* tb/sbr_host_model.sv */
// remote host model issuing queries and mask writes
`timescale 1ns/1ns
module sbr_host_model
    import sbr_pkg::*;
(
    input  wire logic         clk_sys_i,
    input  wire logic         reply_valid_i,
    input  wire logic [7:0]   reply_data_i,
    output sbr_query_s        query_o,
    output sbr_mask_wr_s      mask_wr_o
);
    initial begin
        query_o = '0;
        mask_wr_o = '0;
    end

    // ============================================================
    // query: fields scrambled once the strobe is gone
    task automatic ask(input sbr_sel_e sel, input logic by_bit, input logic [2:0] idx,
                       output logic [7:0] data, output logic ok);
        ok = 1'b0;
        data = 8'h00;
        @(posedge clk_sys_i);
        query_o <= '{1'b1, sel, by_bit, idx};
        @(posedge clk_sys_i);
        query_o <= {1'b0, ~query_o[6:0]};
        for (int n = 0; n < 4 && !ok; n++) begin
            @(posedge clk_sys_i);
            if (reply_valid_i === 1'b1) begin
                ok = 1'b1;
                data = reply_data_i;
            end
        end
    endtask

    // ============================================================
    // mask write, done before summaries are relied on
    task automatic set_mask(input sbr_mask_e which, input logic [7:0] value);
        @(posedge clk_sys_i);
        mask_wr_o <= '{1'b1, which, value};
        @(posedge clk_sys_i);
        mask_wr_o <= {1'b0, ~mask_wr_o[9:0]};
    endtask
endmodule

/* tb/tb.sv */
// self-checking bench for the status byte block
`timescale 1ns/1ns
module tb;
    import sbr_pkg::*;
    logic         clk_sys_i, reset_i, psc_wr_i, psc_val_i, clear_status_i, serial_poll_done_i;
    logic         sweep_idle_i, mod_enabled_i, panel_service_request_i, out_queue_nonempty_i;
    logic         cmd_queue_empty_i, ext_clk_locked_i, nv_psc_i;
    logic [7:0]   nv_sp_mask_i, nv_std_mask_i, nv_gen_mask_i, rd, reply_data_o, sp_mask_o, std_mask_o, gen_mask_o;
    logic         reply_valid_o, srq_o, psc_o, init_done_o;
    sbr_query_s   query_i;
    sbr_mask_wr_s mask_wr_i;
    sbr_std_ev_s  std_ev_i;
    sbr_gen_ev_s  gen_ev_i;
    logic [12:0]  rows [4];
    int           num_errors = 0;
    int           num_checks = 0;

    sbr_status #(.WARMUP_CYC(32'h10)) DUT (.clk_sys_i, .reset_i, .query_i, .mask_wr_i, .psc_wr_i, .psc_val_i,
        .clear_status_i, .serial_poll_done_i, .std_ev_i, .gen_ev_i, .sweep_idle_i, .mod_enabled_i,
        .panel_service_request_i, .out_queue_nonempty_i, .cmd_queue_empty_i, .ext_clk_locked_i, .nv_psc_i,
        .nv_sp_mask_i, .nv_std_mask_i, .nv_gen_mask_i, .reply_valid_o, .reply_data_o, .srq_o, .sp_mask_o,
        .std_mask_o, .gen_mask_o, .psc_o, .init_done_o);
    sbr_host_model HOST (.clk_sys_i, .reply_valid_i(reply_valid_o), .reply_data_i(reply_data_o),
        .query_o(query_i), .mask_wr_o(mask_wr_i));

    initial begin
        clk_sys_i = 1'b0;
        forever #20 clk_sys_i = ~clk_sys_i;
    end

    // ============================================================
    // helpers
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic q(input sbr_sel_e s, input logic b, input logic [2:0] i, input logic [7:0] exp);
        logic ok;
        HOST.ask(s, b, i, rd, ok);
        if (!ok) begin
            num_errors++;
            wrap_up();
        end
        chk(rd, exp);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask
    task automatic ev(input sbr_std_ev_s s, input sbr_gen_ev_s g);
        @(posedge clk_sys_i);
        std_ev_i <= s;
        gen_ev_i <= g;
        @(posedge clk_sys_i);
        std_ev_i <= '0;
        gen_ev_i <= '0;
    endtask
    task automatic do_reset(input logic psc);
        nv_psc_i <= psc;
        reset_i <= 1'b1;
        tick(10);
        chk(reply_data_o | sp_mask_o | gen_mask_o | {7'h00, init_done_o}, 8'h00);
        reset_i <= 1'b0;
        tick(2);
        chk({6'h00, init_done_o, psc_o}, {6'h00, 1'b1, psc});
    endtask

    // ============================================================
    // main sequence
    initial begin
        {reset_i, psc_wr_i, psc_val_i, clear_status_i, serial_poll_done_i, nv_psc_i} = 6'h21;
        {sweep_idle_i, mod_enabled_i, panel_service_request_i, out_queue_nonempty_i} = 4'h0;
        {cmd_queue_empty_i, ext_clk_locked_i} = 2'h0;
        {nv_sp_mask_i, nv_std_mask_i, nv_gen_mask_i} = {8'h91, 8'h22, 8'hB3};
        std_ev_i = '0;
        gen_ev_i = '0;
        rows = '{{5'h00, 8'h00}, {5'h15, 8'h85}, {5'h0A, 8'h12}, {5'h1F, 8'h97}};
        do_reset(1'b1);
        chk(sp_mask_o | std_mask_o | gen_mask_o, 8'h00);
        q(SBR_SEL_STD, 1'b0, 3'h0, 8'h80);
        q(SBR_SEL_STD, 1'b0, 3'h0, 8'h00);
        $display("power-on test done");
        foreach (rows[k]) begin
            @(posedge clk_sys_i);
            {cmd_queue_empty_i, out_queue_nonempty_i, panel_service_request_i, mod_enabled_i, sweep_idle_i} <= rows[k][12:8];
            q(SBR_SEL_SPOLL, 1'b0, 3'h0, rows[k][7:0]);
            q(SBR_SEL_SPOLL, 1'b1, 3'h7, {7'h00, rows[k][12]});
        end
        $display("poll table done");
        ev(4'h0, 6'h3F);
        q(SBR_SEL_GEN, 1'b1, 3'h0, 8'h01);
        q(SBR_SEL_GEN, 1'b0, 3'h0, 8'hFA);
        q(SBR_SEL_GEN, 1'b0, 3'h0, 8'h10);
        ext_clk_locked_i <= 1'b1;
        tick(4);
        q(SBR_SEL_GEN, 1'b0, 3'h0, 8'h14);
        fork
            q(SBR_SEL_GEN, 1'b0, 3'h0, 8'h14);
            ev(4'h0, 6'h20);
        join
        q(SBR_SEL_GEN, 1'b0, 3'h0, 8'h15);
        ev(4'hF, 6'h3F);
        q(SBR_SEL_STD, 1'b1, 3'h4, 8'h01);
        q(SBR_SEL_STD, 1'b0, 3'h0, 8'h64);
        ev(4'h1, 6'h0);
        // read lands one cycle after the clear, so the clear alone must empty the byte
        fork
            begin
                clear_status_i <= 1'b1;
                tick(1);
                clear_status_i <= 1'b0;
            end
            q(SBR_SEL_STD, 1'b0, 3'h0, 8'h00);
        join
        q(SBR_SEL_GEN, 1'b0, 3'h0, 8'h14);
        q(sbr_sel_e'(3'h7), 1'b0, 3'h0, 8'h00);
        $display("event byte test done");
        HOST.set_mask(SBR_MASK_STD, 8'h10);
        HOST.set_mask(SBR_MASK_GEN, 8'h01);
        HOST.set_mask(SBR_MASK_SP, 8'h28);
        ev(4'h4, 6'h0);
        tick(2);
        chk({7'h00, srq_o}, 8'h01);
        q(SBR_SEL_SPOLL, 1'b0, 3'h0, 8'hF7);
        serial_poll_done_i <= 1'b1;
        tick(1);
        serial_poll_done_i <= 1'b0;
        tick(4);
        chk({7'h00, srq_o}, 8'h00);
        ev(4'h0, 6'h20);
        tick(2);
        chk({7'h00, srq_o}, 8'h01);
        q(SBR_SEL_STD, 1'b0, 3'h0, 8'h10);
        q(SBR_SEL_SPOLL, 1'b1, 3'h5, 8'h00);
        fork
            ev(4'h4, 6'h0);
            begin
                tick(1);
                q(SBR_SEL_STD, 1'b0, 3'h0, 8'h10);
            end
        join
        $display("service request test done");
        psc_wr_i <= 1'b1;
        tick(1);
        psc_wr_i <= 1'b0;
        tick(1);
        chk({7'h00, psc_o}, 8'h00);
        do_reset(1'b0);
        chk(sp_mask_o ^ std_mask_o ^ gen_mask_o, 8'h00);
        chk(std_mask_o, 8'h22);
        q(SBR_SEL_STD, 1'b0, 3'h0, 8'h80);
        q(SBR_SEL_SP_MASK, 1'b0, 3'h0, 8'h91);
        q(SBR_SEL_GEN_MASK, 1'b0, 3'h0, 8'hB3);
        q(SBR_SEL_PSC, 1'b0, 3'h0, 8'h00);
        // restored poll mask has bit 7: drop and raise the empty-queue level
        cmd_queue_empty_i <= 1'b0;
        serial_poll_done_i <= 1'b1;
        tick(1);
        serial_poll_done_i <= 1'b0;
        tick(2);
        chk({7'h00, srq_o}, 8'h00);
        cmd_queue_empty_i <= 1'b1;
        tick(2);
        chk({7'h00, srq_o}, 8'h01);
        $display("mask restore test done");
        wrap_up();
    end
endmodule
